// >>> hdl/urst_bank.sv
// Purpose: register bank and reset state of one uart channel
// Assumes: async parallel bus strobes, synced to i_clk before use
// Notes:   i_power_up is the power-on reset, i_reset the reset pin
`timescale 1ns/1ps
module urst_bank (
	input  wire logic       i_clk,
	input  wire logic       i_reset,
	input  wire logic       i_power_up,
	input  wire logic       i_cs_n,
	input  wire logic       i_ior_n,
	input  wire logic       i_iow_n,
	input  wire logic [2:0] i_addr,
	input  wire logic [7:0] i_data,
	input  wire logic       i_cts_n,
	input  wire logic       i_dsr_n,
	input  wire logic       i_ring_indicator_n,
	input  wire logic       i_carrier_detect_n,
	output logic      [7:0] o_data,
	output logic            o_data_oe,
	output logic            o_tx,
	output logic            o_rts_n,
	output logic            o_dtr_n,
	output logic            o_general_output_two_n,
	output logic            o_receive_ready_n,
	output logic            o_transmit_ready_n,
	output logic            o_int,
	output logic            o_int_oe
);
	import urst_pkg::*;

	function automatic logic hit(input logic [2:0] a, input logic [2:0] r);
		return a == r;
	endfunction : hit

	// bus synchronisers
	logic [2:0] strb1_r;
	logic [2:0] strb2_r;
	logic [2:0] strb3_r;
	logic [10:0] bus1_r;
	logic [10:0] bus2_r;

	logic [7:0] div_high_r;
	logic [7:0] div_low_r;
	logic [7:0] frac_div_r;
	logic [7:0] int_en_r;
	logic [7:0] fifo_ctl_r;
	logic [7:0] line_ctl_r;
	logic [7:0] modem_ctl_r;
	logic [7:0] line_stat_r;
	logic [7:0] scratch_r;
	logic [7:0] enh_feat_r;
	logic [7:0] resume1_r;
	logic [7:0] resume2_r;
	logic [7:0] stop1_r;
	logic [7:0] stop2_r;
	logic [7:0] rdata_r;
	logic       rd_act_r;
	logic       tx_r;
	logic       rx_ready_n_r;
	logic       tx_ready_n_r;

	urst_mstat_if mst_if ();

	wire        rst_all  = i_reset | i_power_up;
	wire        cs       = ~strb2_r[0];
	wire        rd_lvl   = cs & ~strb2_r[1];
	wire        wr_go    = cs & ~strb2_r[2] & strb3_r[2];
	wire        rd_end   = strb2_r[1] & ~strb3_r[1];
	wire [2:0]  addr     = bus2_r[10:8];
	wire [7:0]  wdat     = bus2_r[7:0];
	wire        dlab     = line_ctl_r[DIV_ACCESS_BIT];
	wire        alt_sel  = (line_ctl_r == ALT_PAGE_KEY);
	wire        enh      = enh_feat_r[ENH_ENABLE_BIT];
	wire        frac_sel = dlab & ~alt_sel & enh;
	wire        ms_int   = int_en_r[MODEM_INT_EN_BIT]
	                       & (|mst_if.status[3:0]); // [R7]
	wire [7:0]  ist_val  = ms_int ? INT_STAT_MODEM : RST_INT_STAT;
	wire [7:0]  ien_wm   = enh ? 8'hff : ~ENH_MASK;
	wire [7:0]  mctl_wm  = enh ? 8'hff : ~MODEM_CTL_ENH_MASK;
	wire        wr_divl  = wr_go & hit(addr, ADDR_DATA) & dlab & ~alt_sel;
	wire        wr_divh  = wr_go & hit(addr, ADDR_INT_EN) & dlab & ~alt_sel;
	wire        wr_frac  = wr_go & hit(addr, ADDR_INT_STAT) & frac_sel;
	wire        wr_ien   = wr_go & hit(addr, ADDR_INT_EN) & ~dlab;
	wire        wr_fifo  = wr_go & hit(addr, ADDR_INT_STAT) & ~dlab;
	wire        wr_enh   = wr_go & hit(addr, ADDR_INT_STAT) & alt_sel;
	wire        wr_line  = wr_go & hit(addr, ADDR_LINE_CTL);
	wire        wr_modem = wr_go & hit(addr, ADDR_MODEM_CTL) & ~alt_sel;
	wire        wr_scr   = wr_go & hit(addr, ADDR_SCRATCH) & ~alt_sel;
	wire        wr_res1  = wr_go & hit(addr, ADDR_MODEM_CTL) & alt_sel;
	wire        wr_res2  = wr_go & hit(addr, ADDR_LINE_STAT) & alt_sel;
	wire        wr_stp1  = wr_go & hit(addr, ADDR_MODEM_STAT) & alt_sel;
	wire        wr_stp2  = wr_go & hit(addr, ADDR_SCRATCH) & alt_sel;
	wire        loop     = modem_ctl_r[LOOPBACK_BIT];
	logic [7:0] rmux;

	assign mst_if.loopback = loop; // [R6]
	assign mst_if.loop_src = {modem_ctl_r[3], modem_ctl_r[2],
	                          modem_ctl_r[0], modem_ctl_r[1]};
	assign mst_if.clear    = rd_end & hit(addr, ADDR_MODEM_STAT) & ~alt_sel;

	urst_mstat urst_mstat_i (
		.i_clk     (i_clk),
		.i_reset   (rst_all),
		.i_modem_n ({i_carrier_detect_n, i_ring_indicator_n, i_dsr_n,
		             i_cts_n}),
		.mst       (mst_if.tracker)
	);

	// read selection
	always_comb begin
		rmux = 8'h00;
		case (addr)
		ADDR_DATA:       rmux = dlab ? div_low_r : 8'h00;
		ADDR_INT_EN:     rmux = dlab ? div_high_r : int_en_r;
		ADDR_INT_STAT:   rmux = alt_sel ? enh_feat_r
		                        : (frac_sel ? frac_div_r : ist_val);
		ADDR_LINE_CTL:   rmux = line_ctl_r;
		ADDR_MODEM_CTL:  rmux = alt_sel ? resume1_r : modem_ctl_r; // [R5]
		ADDR_LINE_STAT:  rmux = alt_sel ? resume2_r : line_stat_r;
		ADDR_MODEM_STAT: rmux = alt_sel ? stop1_r : mst_if.status;
		ADDR_SCRATCH:    rmux = alt_sel ? stop2_r : scratch_r;
		default:         rmux = 8'h00;
		endcase
	end

	always_ff @(posedge i_clk) begin
		strb1_r <= {i_iow_n, i_ior_n, i_cs_n};
		strb2_r <= strb1_r;
		strb3_r <= strb2_r;
		bus1_r  <= {i_addr, i_data};
		bus2_r  <= bus1_r;
	end

	// divisor latches: power-up only
	always_ff @(posedge i_clk) begin
		if (i_power_up) begin
			div_high_r <= RST_DIV_HIGH; // [R1]
			div_low_r  <= RST_DIV_LOW; // [R1]
		end else begin
			if (wr_divh) begin
				div_high_r <= wdat; // [R2]
			end
			if (wr_divl) begin
				div_low_r <= wdat; // [R2]
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (rst_all) begin
			frac_div_r  <= RST_ZERO;
			int_en_r    <= RST_ZERO;
			fifo_ctl_r  <= RST_ZERO;
			line_ctl_r  <= RST_ZERO;
			modem_ctl_r <= RST_ZERO;
			line_stat_r <= RST_LINE_STAT;
			scratch_r   <= RST_SCRATCH;
			enh_feat_r  <= RST_ZERO;
		end else begin
			if (wr_frac) begin
				frac_div_r <= wdat;
			end
			if (wr_ien) begin
				int_en_r <= (wdat & ien_wm) | (int_en_r & ~ien_wm);
			end
			if (wr_fifo) begin
				fifo_ctl_r <= wdat;
			end
			if (wr_line) begin
				line_ctl_r <= wdat;
			end
			if (wr_modem) begin
				modem_ctl_r <= (wdat & mctl_wm) | (modem_ctl_r & ~mctl_wm);
			end
			if (wr_scr) begin
				scratch_r <= wdat;
			end
			if (wr_enh) begin
				enh_feat_r <= wdat;
			end
		end
	end

	// flow-control characters
	always_ff @(posedge i_clk) begin
		if (rst_all) begin
			resume1_r <= RST_ZERO;
			resume2_r <= RST_ZERO;
			stop1_r   <= RST_ZERO;
			stop2_r   <= RST_ZERO;
		end else begin
			if (wr_res1) begin
				resume1_r <= wdat; // [R5]
			end
			if (wr_res2) begin
				resume2_r <= wdat; // [R5]
			end
			if (wr_stp1) begin
				stop1_r <= wdat; // [R5]
			end
			if (wr_stp2) begin
				stop2_r <= wdat; // [R5]
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (rst_all) begin
			rdata_r      <= RST_ZERO;
			rd_act_r     <= 1'b0;
			tx_r         <= 1'b1; // [R8]
			rx_ready_n_r <= 1'b1; // [R8]
			tx_ready_n_r <= 1'b0; // [R8]
		end else begin
			rdata_r      <= rmux;
			rd_act_r     <= rd_lvl;
			tx_r         <= 1'b1;
			rx_ready_n_r <= 1'b1;
			tx_ready_n_r <= 1'b0;
		end
	end

	// modem outputs inactive in loopback
	assign o_data                 = rdata_r;
	assign o_data_oe              = rd_act_r;
	assign o_tx                   = tx_r;
	assign o_rts_n                = loop | ~modem_ctl_r[1]; // [R8]
	assign o_dtr_n                = loop | ~modem_ctl_r[0]; // [R8]
	assign o_general_output_two_n = loop | ~modem_ctl_r[3]; // [R8]
	assign o_receive_ready_n      = rx_ready_n_r;
	assign o_transmit_ready_n     = tx_ready_n_r;
	assign o_int                  = ms_int; // [R7]
	assign o_int_oe               = modem_ctl_r[3] & ~loop; // [R8]

	default clocking cb @(posedge i_clk); endclocking

	AST_DIV_PWRUP: assert property ( // [R1]
		i_power_up |=> div_high_r == RST_DIV_HIGH
		&& div_low_r == RST_DIV_LOW)
		else $error("divisor not initialised at power-up");
	AST_DIV_KEEP: assert property ( // [R2]
		i_reset && !i_power_up |=> $stable(div_high_r)
		&& $stable(div_low_r))
		else $error("divisor changed by reset pin");
	AST_DELTA_CLR: assert property ( // [R3]
		rst_all |=> mst_if.status[3:0] == 4'h0)
		else $error("modem change flags not cleared");
	AST_MSTAT_LVL: assert property ( // [R4]
		disable iff (rst_all)
		!loop && $stable(i_cts_n)[*3] |-> mst_if.status[4] == ~i_cts_n)
		else $error("status bit 4 not inverted pin");
	AST_LOOP_SRC: assert property ( // [R6]
		loop |-> mst_if.status[7:4] == mst_if.loop_src)
		else $error("loopback status mismatch");
	AST_XCHAR: assert property ( // [R5]
		disable iff (rst_all) wr_stp2 |=> stop2_r == $past(wdat))
		else $error("stop char two not stored");
	AST_MS_INT: assert property ( // [R7]
		disable iff (rst_all)
		int_en_r[MODEM_INT_EN_BIT] && mst_if.status[0] |-> o_int)
		else $error("modem interrupt not raised");
	AST_RST_PINS: assert property ( // [R8]
		rst_all |=> o_tx && o_rts_n && o_dtr_n && o_general_output_two_n
		&& o_receive_ready_n && !o_transmit_ready_n && !o_int_oe)
		else $error("pin reset state wrong");
	AST_DELTA_SET: assert property ( // [R7]
		disable iff (rst_all)
		mst_if.status[7:4] != $past(mst_if.status[7:4])
		|=> mst_if.status[3:0] != 4'h0)
		else $error("change flag not set");

	COV_LOOP: cover property (wr_modem ##1 loop);
	COV_RESUME1: cover property (wr_res1);
	COV_INT: cover property ($rose(o_int));
	COV_MSTAT_RD: cover property (mst_if.clear && |mst_if.status[3:0]);
endmodule : urst_bank

// >>> hdl/urst_pkg.sv
// Purpose: constants for the channel register bank and its reset state
// Assumes: 3-bit register addressing, 8-bit data
// Notes:   register bank of one channel, no serial datapath
// Summary of operation
// R1: a power-up loads the divisor high byte with 0x00 and the low byte with 0x01.
// R2: the divisor bytes initialise only at power-up and keep their contents on reset.
// R3: reset clears the four modem change flags in modem status bits 3-0.
// R4: right after reset modem status bits 7-4 show the inverted modem input pins.
// R5: four 8-bit read/write registers hold two stop and two resume characters.
// R6: modem status bits 7-4 follow the inverted pins, or modem control in loopback.
// R7: a change flag sets on an input change and interrupts when enable bit 3 is set.
// R8: reset drives serial out, modem and receive ready outputs high, transmit ready low, interrupt undriven.
package urst_pkg;
	localparam logic [2:0] ADDR_DATA          = 3'h0;
	localparam logic [2:0] ADDR_INT_EN        = 3'h1;
	localparam logic [2:0] ADDR_INT_STAT      = 3'h2;
	localparam logic [2:0] ADDR_LINE_CTL      = 3'h3;
	localparam logic [2:0] ADDR_MODEM_CTL     = 3'h4;
	localparam logic [2:0] ADDR_LINE_STAT     = 3'h5;
	localparam logic [2:0] ADDR_MODEM_STAT    = 3'h6;
	localparam logic [2:0] ADDR_SCRATCH       = 3'h7;
	localparam logic [7:0] ALT_PAGE_KEY       = 8'hbf;
	localparam int         DIV_ACCESS_BIT     = 7;
	localparam int         ENH_ENABLE_BIT     = 4;
	localparam int         MODEM_INT_EN_BIT   = 3;
	localparam int         LOOPBACK_BIT       = 4;
	localparam logic [7:0] RST_DIV_HIGH       = 8'h00;
	localparam logic [7:0] RST_DIV_LOW        = 8'h01;
	localparam logic [7:0] RST_ZERO           = 8'h00;
	localparam logic [7:0] RST_INT_STAT       = 8'h01;
	localparam logic [7:0] RST_LINE_STAT      = 8'h60;
	localparam logic [7:0] RST_SCRATCH        = 8'hff;
	localparam logic [7:0] INT_STAT_MODEM     = 8'h00;
	localparam logic [7:0] ENH_MASK           = 8'hf0;
	localparam logic [7:0] MODEM_CTL_ENH_MASK = 8'he0;
endpackage : urst_pkg

// >>> hdl/urst_msr_if.sv
// Purpose: carries modem status between bank and status tracker
// Assumes: single clock i_clk
// Notes:   bank drives controls, tracker returns status
`timescale 1ns/1ps
interface urst_mstat_if;
	logic       loopback;
	logic [3:0] loop_src;
	logic       clear;
	logic [7:0] status;
	modport bank    (output loopback, output loop_src, output clear,
	                 input status);
	modport tracker (input loopback, input loop_src, input clear,
	                 output status);
endinterface : urst_mstat_if

// >>> hdl/urst_msr.sv
// Purpose: modem status tracker with change flags
// Assumes: modem pins asynchronous, active low
// Notes:   pins clear-to-send, set-ready, ring, carrier in bits 0-3
`timescale 1ns/1ps
module urst_mstat (
	input  wire logic       i_clk,
	input  wire logic       i_reset,
	input  wire logic [3:0] i_modem_n,
	urst_mstat_if.tracker   mst
);
	import urst_pkg::*;

	logic [3:0] sync1_r;
	logic [3:0] sync2_r;
	logic [3:0] prev_r;
	logic [3:0] delta_r;
	logic [3:0] delta_nxt;
	wire  [3:0] level;
	wire  [3:0] change;

	always_ff @(posedge i_clk) begin
		sync1_r <= i_modem_n;
		sync2_r <= sync1_r;
	end

	// complement of pins, or modem control in loopback
	assign level  = mst.loopback ? mst.loop_src : ~sync2_r; // [R6] [R4]
	assign change = level ^ prev_r;
	// set wins over read clear
	assign delta_nxt = (mst.clear ? 4'h0 : delta_r) | change; // [R7]

	always_ff @(posedge i_clk) begin
		prev_r <= level;
		if (i_reset) begin
			delta_r <= 4'h0; // [R3]
		end else begin
			delta_r <= delta_nxt;
		end
	end

	assign mst.status = {level, delta_r};
endmodule : urst_mstat

// >>> sim/urst_host.sv
// Purpose: host processor model on the channel register bus
// Assumes: strobes change just after rising edges of i_clk
// Notes:   released data lines show the inverse of the last value
`timescale 1ns/1ps
module urst_host (
	input  wire logic       i_clk,
	input  wire logic [7:0] i_rdata,
	input  wire logic       i_rdata_oe,
	output logic            o_cs_n,
	output logic            o_ior_n,
	output logic            o_iow_n,
	output logic      [2:0] o_addr,
	output logic      [7:0] o_data
);
	initial begin
		o_cs_n  = 1'b1;
		o_ior_n = 1'b1;
		o_iow_n = 1'b1;
		o_addr  = 3'h0;
		o_data  = 8'h00;
	end
	task automatic gap(input int n);
		repeat (n) @(posedge i_clk);
	endtask : gap
	// strobe low four edges, then high four edges
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		o_addr  <= a;
		o_data  <= d;
		o_cs_n  <= 1'b0;
		o_iow_n <= 1'b0;
		gap(4);
		o_cs_n  <= 1'b1;
		o_iow_n <= 1'b1;
		o_data  <= ~d;
		gap(4);
	endtask : wr
	// hold strobe until data enable is seen, bounded
	task automatic rd(input logic [2:0] a, output logic [7:0] d,
		output logic ok);
		ok = 1'b0;
		d  = 8'h00;
		o_addr  <= a;
		o_cs_n  <= 1'b0;
		o_ior_n <= 1'b0;
		for (int i = 0; i < 8 && !ok; i++) begin
			@(posedge i_clk);
			ok = (i_rdata_oe === 1'b1);
			d  = i_rdata;
		end
		o_cs_n  <= 1'b1;
		o_ior_n <= 1'b1;
		for (int i = 0; i < 8 && i_rdata_oe !== 1'b0; i++) begin
			@(posedge i_clk);
		end
		gap(4);
	endtask : rd
endmodule : urst_host

// >>> sim/urst_bank_tb_top.sv
// Purpose: self-checking bench for the channel register bank
// Assumes: host model issues every register bus cycle
// Notes:   modem pins start at 0, 1, 0, 1 in status order
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
	num_checks++; \
	if ((g) !== (e)) begin \
		error_cnt++; \
		$display("unexpected %s exp %h got %h", nm, e, g); \
	end \
end
module urst_bank_tb_top;
	import urst_pkg::*;
	logic       clk = 1'b0;
	logic       rst = 1'b1;
	logic       pwr = 1'b1;
	logic       cts_n = 1'b0;
	logic       dsr_n = 1'b1;
	logic       rng_n = 1'b0;
	logic       car_n = 1'b1;
	logic       cs_n, ior_n, iow_n, data_oe, tx, rts_n, dtr_n, op2_n;
	logic       rxr_n, txr_n, int_o, int_oe, ok;
	logic [2:0] addr;
	logic [7:0] wdata, rdata, v;
	int         error_cnt = 0;
	int         num_checks = 0;
	wire  [6:0] pins = {tx, rts_n, dtr_n, op2_n, rxr_n, txr_n, int_oe};
	initial begin
		forever #50 clk = ~clk;
	end
	urst_bank urst_bank_i (.i_clk(clk), .i_reset(rst), .i_power_up(pwr),
		.i_cs_n(cs_n), .i_ior_n(ior_n), .i_iow_n(iow_n), .i_addr(addr),
		.i_data(wdata), .i_cts_n(cts_n), .i_dsr_n(dsr_n),
		.i_ring_indicator_n(rng_n), .i_carrier_detect_n(car_n),
		.o_data(rdata), .o_data_oe(data_oe), .o_tx(tx), .o_rts_n(rts_n),
		.o_dtr_n(dtr_n), .o_general_output_two_n(op2_n),
		.o_receive_ready_n(rxr_n), .o_transmit_ready_n(txr_n),
		.o_int(int_o), .o_int_oe(int_oe));
	urst_host urst_host_i (.i_clk(clk), .i_rdata(rdata),
		.i_rdata_oe(data_oe), .o_cs_n(cs_n), .o_ior_n(ior_n),
		.o_iow_n(iow_n), .o_addr(addr), .o_data(wdata));
	task automatic wrap_up;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : wrap_up
	task automatic rd(input logic [2:0] a);
		urst_host_i.rd(a, v, ok);
		if (!ok) begin
			error_cnt++;
			wrap_up();
		end
	endtask : rd
	task automatic rc(input logic [2:0] a, input logic [7:0] e);
		rd(a);
		`CHK("register", e, v)
	endtask : rc
	task automatic pulse(input logic p);
		rst <= 1'b1;
		pwr <= p;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		pwr <= 1'b0;
		@(posedge clk);
	endtask : pulse
	initial begin
		pulse(1'b1);
		`CHK("pins", 7'h7c, pins)
		rc(ADDR_INT_STAT, RST_INT_STAT);
		rc(ADDR_LINE_STAT, RST_LINE_STAT);
		rc(ADDR_SCRATCH, RST_SCRATCH);
		rc(ADDR_MODEM_STAT, 8'h50);
		urst_host_i.wr(ADDR_LINE_CTL, 8'h80);
		rc(ADDR_DATA, RST_DIV_LOW);
		rc(ADDR_INT_EN, RST_DIV_HIGH);
		urst_host_i.wr(ADDR_DATA, 8'h34);
		urst_host_i.wr(ADDR_INT_EN, 8'h12);
		urst_host_i.wr(ADDR_LINE_CTL, 8'h00);
		urst_host_i.wr(ADDR_INT_EN, 8'h08);
		urst_host_i.wr(ADDR_MODEM_CTL, 8'h02);
		cts_n <= 1'b1;
		for (int i = 0; i < 10 && int_o !== 1'b1; i++) @(posedge clk);
		`CHK("int", 1'b1, int_o)
		rc(ADDR_INT_STAT, INT_STAT_MODEM);
		rc(ADDR_MODEM_STAT, 8'h41);
		`CHK("int", 1'b0, int_o)
		rc(ADDR_MODEM_STAT, 8'h40);
		dsr_n <= 1'b0;
		rng_n <= 1'b1;
		car_n <= 1'b0;
		repeat (4) @(posedge clk);
		rc(ADDR_MODEM_STAT, 8'hae);
		dsr_n <= 1'b1;
		rng_n <= 1'b0;
		car_n <= 1'b1;
		urst_host_i.wr(ADDR_MODEM_CTL, 8'h12);
		rd(ADDR_MODEM_STAT);
		`CHK("loop", 4'h1, v[7:4])
		urst_host_i.wr(ADDR_MODEM_CTL, 8'h02);
		urst_host_i.wr(ADDR_SCRATCH, 8'h5a);
		pulse(1'b0);
		`CHK("pins", 7'h7c, pins)
		rc(ADDR_SCRATCH, RST_SCRATCH);
		rc(ADDR_MODEM_STAT, 8'h40);
		urst_host_i.wr(ADDR_LINE_CTL, 8'h80);
		rc(ADDR_DATA, 8'h34);
		rc(ADDR_INT_EN, 8'h12);
		urst_host_i.wr(ADDR_LINE_CTL, ALT_PAGE_KEY);
		rc(ADDR_INT_STAT, RST_ZERO);
		for (int a = 4; a < 8; a++) begin
			rc(a[2:0], RST_ZERO);
			urst_host_i.wr(a[2:0], 8'ha0 + a[7:0]);
		end
		for (int a = 4; a < 8; a++) begin
			rc(a[2:0], 8'ha0 + a[7:0]);
		end
		wrap_up();
	end
endmodule : urst_bank_tb_top
